// ### lpm_pkg.sv
package lpm_pkg;

  // Power modes of the controller.
  typedef enum logic [3:0] {
    LPM_RUN       = 4'h0,
    LPM_SLEEP     = 4'h1,
    LPM_LP_RUN    = 4'h2,
    LPM_LP_SLEEP  = 4'h3,
    LPM_STOP0     = 4'h4,
    LPM_STOP1     = 4'h5,
    LPM_STOP2     = 4'h6,
    LPM_STANDBY   = 4'h7,
    LPM_SHUTDOWN  = 4'h8
  } lpm_mode_t;

  // Register word addresses.
  localparam logic [3:0] LPM_ADDR_CTRL = 4'h0;
  localparam logic [3:0] LPM_ADDR_WKEN = 4'h1;
  localparam logic [3:0] LPM_ADDR_CLKG = 4'h2;
  localparam logic [3:0] LPM_ADDR_PULL = 4'h3;
  localparam logic [3:0] LPM_ADDR_STAT = 4'h4;
  localparam logic [3:0] LPM_ADDR_WKFL = 4'h5;

  // Control register fields.
  localparam int LPM_CTRL_MODE_LSB = 0;
  localparam int LPM_CTRL_GO = 4;
  localparam int LPM_CTRL_STOPCLK = 5;
  localparam int LPM_CTRL_SRAM2RET = 6;
  localparam int LPM_CTRL_FLASHPD = 7;
  localparam int LPM_CTRL_MSIWIDE = 8;

  // Wakeup source indices.
  localparam int LPM_NPINS = 5;
  localparam int LPM_WK_PIN0 = 0;
  localparam int LPM_WK_RTC = 5;
  localparam int LPM_WK_WDG = 6;
  localparam int LPM_WK_CSS = 7;
  localparam int LPM_WK_UART = 8;
  localparam int LPM_WK_LPUART = 9;
  localparam int LPM_WK_I2C = 10;
  localparam int LPM_WK_USB = 11;
  localparam int LPM_WK_IRQ = 12;
  localparam int LPM_NWK = 13;

  // Clock selection codes.
  localparam logic [1:0] LPM_SYS_MSI = 2'h0;
  localparam logic [1:0] LPM_SYS_HSI = 2'h1;
  localparam logic [1:0] LPM_MSI_8M = 2'h1;
  localparam logic [1:0] LPM_MSI_48M = 2'h3;
  localparam logic [1:0] LPM_MSI_2M = 2'h0;

  localparam int LPM_NPERIPH = 16;
  localparam logic [31:0] LPM_CTRL_RST = 32'h0;
  localparam logic [31:0] LPM_CLKG_RST = 32'hffffffff;

endpackage

// ### lpm_controller.sv
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Any reset starts in run mode.
// - Sleep stops CPU; any interrupt wakes.
// - Low-power run: low regulator, CPU at 2 MHz.
// - Low-power sleep only from low-power run.
// - Stop gates core clocks, fast oscillators off.
// - Stop: wakeup peripheral may request fast RC.
// - Three stop levels; level 2 lowers leakage.
// - Stop 0 keeps main regulator; others low.
// - Stop exit clock: multispeed or fast RC.
// - Standby powers core off; brownout stays on.
// - Standby I/O pull state chosen by software.
// - Standby loses SRAM; retainable SRAM optional.
// - Standby exits on reset, pins, RTC, CLOCK_SECURITY_MONITOR.
// - After standby clock is multispeed, 8 MHz max.
// - UART receivers wake from stop.
// - I2C address match wakes from stop.
// - USB resume or attach event wakes.
// - Five wakeup pins wake standby or shutdown.
// - Shutdown pull settings dropped on exit.
// - Flash power-down when running from SRAM.
// - SRAM clocks gated independently in sleep.
// - Each peripheral clock individually gateable.
module lpm_controller
  import lpm_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, high.
  input wire logic [3:0] addr, // Register word address.
  input wire logic [31:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  output logic [31:0] rdata, // Read data, one cycle after rd.
  input wire logic [LPM_NPINS-1:0] wakeup_pin, // Dedicated wakeup pins.
  input wire logic cpu_irq, // Any interrupt or event.
  input wire logic rtc_event, // RTC alarm, periodic, timestamp or tamper.
  input wire logic wdg_reset, // Independent watchdog reset.
  input wire logic css_fail, // Clock monitor failure on slow oscillator.
  input wire logic uart_wake, // UART start, address or frame.
  input wire logic lpuart_wake, // Low-power UART wake event.
  input wire logic i2c_addr_match, // I2C slave address match.
  input wire logic usb_wake, // USB resume or attach event.
  input wire logic hsi_request, // Peripheral asks for fast RC in stop.
  output logic cpu_clk_en, // CPU clock enable.
  output logic core_clk_en, // Core domain clock enable.
  output logic core_power_on, // Core domain powered.
  output logic main_reg_on, // Main regulator on.
  output logic lp_reg_on, // Low-power regulator on.
  output logic low_leak, // Core in lower-leakage state.
  output logic pll_en, // PLL enable.
  output logic msi_en, // Multispeed RC enable.
  output logic hsi_en, // Fast internal RC enable.
  output logic hse_en, // Fast external oscillator enable.
  output logic slow_osc_en, // Slow oscillators running.
  output logic bor_en, // Brownout reset active.
  output logic [1:0] sysclk_sel, // System clock source.
  output logic [1:0] msi_range, // Multispeed RC frequency range.
  output logic cpu_fast_ok, // High when CPU may exceed 2 MHz.
  output logic flash_pd, // Flash powered down and clock gated.
  output logic main_sram_clk_en, // Main SRAM clock.
  output logic ret_sram_clk_en, // Retainable SRAM clock.
  output logic main_sram_pwr, // Main SRAM powered.
  output logic ret_sram_pwr, // Retainable SRAM powered.
  output logic [LPM_NPERIPH-1:0] periph_clk_en, // Per-peripheral clock enables.
  output logic [1:0] io_pull, // Standby pull: 0 float, 1 up, 2 down.
  output logic regs_lost, // Pulse: register contents lost on standby.
  output logic wake_pulse // Pulse: a wakeup ended a low-power mode.
);

  typedef struct packed {
    lpm_mode_t mode;
    logic [31:0] ctrl;
    logic [LPM_NWK-1:0] wken;
    logic [31:0] clkg;
    logic [1:0] pull;
    logic [LPM_NPINS-1:0] pin_pol;
    logic [LPM_NPINS-1:0] pin_prev;
    logic [LPM_NWK-1:0] wkfl;
    logic [31:0] rdata;
    logic [1:0] sysclk;
    logic [1:0] msir;
    logic lost;
    logic wake;
    logic [1:0] io_pull;
  } lpm_state_t;

  lpm_state_t s_q, s_d;

  logic [LPM_NWK-1:0] ev;
  logic [LPM_NPINS-1:0] pin_edge;
  lpm_mode_t req_mode;
  logic stop_m, sleep_m, stby_m;

  // Wakeup pin edges with per-pin polarity.
  always_comb begin
    for (int i = 0; i < LPM_NPINS; i++) begin
      pin_edge[i] = s_q.pin_pol[i] ? (s_q.pin_prev[i] & ~wakeup_pin[i])
                                   : (~s_q.pin_prev[i] & wakeup_pin[i]);
    end
  end

  // Collected wakeup events.
  always_comb begin
    ev = '0;
    ev[LPM_WK_PIN0 +: LPM_NPINS] = pin_edge;
    ev[LPM_WK_RTC] = rtc_event;
    ev[LPM_WK_WDG] = wdg_reset;
    ev[LPM_WK_CSS] = css_fail;
    ev[LPM_WK_UART] = uart_wake;
    ev[LPM_WK_LPUART] = lpuart_wake;
    ev[LPM_WK_I2C] = i2c_addr_match;
    ev[LPM_WK_USB] = usb_wake;
    ev[LPM_WK_IRQ] = cpu_irq;
  end

  assign req_mode = lpm_mode_t'(wdata[LPM_CTRL_MODE_LSB +: 4]);
  assign stop_m = (s_q.mode == LPM_STOP0) || (s_q.mode == LPM_STOP1) ||
                  (s_q.mode == LPM_STOP2);
  assign sleep_m = (s_q.mode == LPM_SLEEP) || (s_q.mode == LPM_LP_SLEEP);
  assign stby_m = (s_q.mode == LPM_STANDBY) || (s_q.mode == LPM_SHUTDOWN);

  // Next state: register access, mode entry and wakeup.
  always_comb begin
    logic [LPM_NWK-1:0] wk;
    logic stop_src;
    logic stby_src;
    wk = '0;
    stop_src = 1'b0;
    stby_src = 1'b0;
    s_d = s_q;
    s_d.lost = 1'b0;
    s_d.wake = 1'b0;
    s_d.pin_prev = wakeup_pin;
    wk = ev & s_q.wken;
    stop_src = |(wk & ~(LPM_NWK'(1) << LPM_WK_IRQ));
    stby_src = |wk[LPM_WK_PIN0 +: LPM_NPINS] | wk[LPM_WK_RTC] | wk[LPM_WK_WDG] |
               (wk[LPM_WK_CSS] & (s_q.mode == LPM_STANDBY));
    if (!stby_m) begin
      s_d.wkfl = s_q.wkfl | wk;
    end else begin
      s_d.wkfl = s_q.wkfl | (wk & {{(LPM_NWK-LPM_NPINS-3){1'b0}}, {3{1'b1}},
                                   {LPM_NPINS{1'b1}}});
    end
    // Register reads.
    s_d.rdata = '0;
    if (rd) begin
      case (addr)
        LPM_ADDR_CTRL: s_d.rdata = s_q.ctrl;
        LPM_ADDR_WKEN: s_d.rdata = 32'(s_q.wken);
        LPM_ADDR_CLKG: s_d.rdata = s_q.clkg;
        LPM_ADDR_PULL: s_d.rdata = {25'h0, s_q.pin_pol, s_q.pull}; // Same layout as the write.
        LPM_ADDR_STAT: s_d.rdata = {26'h0, s_q.sysclk, s_q.mode};
        LPM_ADDR_WKFL: s_d.rdata = 32'(s_q.wkfl);
        default: s_d.rdata = '0;
      endcase
    end
    // Register writes; the go bit requests a mode entry.
    if (wr) begin
      case (addr)
        LPM_ADDR_CTRL: begin
          s_d.ctrl = wdata & ~(32'h1 << LPM_CTRL_GO);
          if (wdata[LPM_CTRL_GO]) begin
            case (req_mode)
              LPM_RUN, LPM_SLEEP, LPM_STOP0, LPM_STOP1, LPM_STOP2, LPM_STANDBY,
              LPM_SHUTDOWN: begin
                if (s_q.mode == LPM_RUN || s_q.mode == LPM_LP_RUN) begin
                  s_d.mode = (s_q.mode == LPM_LP_RUN && req_mode == LPM_SLEEP)
                             ? LPM_LP_SLEEP : req_mode;
                end
              end
              LPM_LP_RUN: begin
                if (s_q.mode == LPM_RUN) begin
                  s_d.mode = LPM_LP_RUN;
                  s_d.msir = LPM_MSI_2M;
                end
              end
              LPM_LP_SLEEP: begin
                if (s_q.mode == LPM_LP_RUN) begin
                  s_d.mode = LPM_LP_SLEEP;
                end
              end
              default: s_d.mode = s_q.mode;
            endcase
            if (req_mode == LPM_STANDBY && s_d.mode == LPM_STANDBY) begin
              s_d.lost = 1'b1;
              s_d.io_pull = s_q.pull;
            end
            if (req_mode == LPM_SHUTDOWN && s_d.mode == LPM_SHUTDOWN) begin
              s_d.lost = 1'b1;
              s_d.io_pull = s_q.pull;
            end
          end
        end
        LPM_ADDR_WKEN: s_d.wken = wdata[LPM_NWK-1:0];
        LPM_ADDR_CLKG: s_d.clkg = wdata;
        LPM_ADDR_PULL: begin
          s_d.pull = wdata[1:0];
          s_d.pin_pol = wdata[2 +: LPM_NPINS];
        end
        LPM_ADDR_WKFL: s_d.wkfl = (s_q.wkfl & ~wdata[LPM_NWK-1:0]) | wk;
        default: s_d.ctrl = s_d.ctrl;
      endcase
    end
    // Wakeup handling per mode.
    case (s_q.mode)
      LPM_SLEEP: if (ev[LPM_WK_IRQ] | stop_src) begin
        s_d.mode = LPM_RUN;
        s_d.wake = 1'b1;
      end
      LPM_LP_SLEEP: if (ev[LPM_WK_IRQ] | stop_src) begin
        s_d.mode = LPM_LP_RUN;
        s_d.wake = 1'b1;
      end
      LPM_STOP0, LPM_STOP1, LPM_STOP2: if (stop_src) begin
        s_d.mode = LPM_RUN;
        s_d.wake = 1'b1;
        s_d.sysclk = s_q.ctrl[LPM_CTRL_STOPCLK] ? LPM_SYS_HSI : LPM_SYS_MSI;
        s_d.msir = s_q.ctrl[LPM_CTRL_MSIWIDE] ? LPM_MSI_48M : LPM_MSI_8M;
      end
      LPM_STANDBY, LPM_SHUTDOWN: if (stby_src) begin
        s_d.mode = LPM_RUN;
        s_d.wake = 1'b1;
        s_d.sysclk = LPM_SYS_MSI;
        s_d.msir = LPM_MSI_8M;
        s_d.io_pull = 2'h0;
        s_d.ctrl = LPM_CTRL_RST;
        s_d.clkg = LPM_CLKG_RST;
      end
      default: s_d.mode = s_d.mode;
    endcase
  end

  // State register; reset lands in run mode.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{mode: LPM_RUN, ctrl: LPM_CTRL_RST, wken: '0, clkg: LPM_CLKG_RST,
               pull: 2'h0, pin_pol: '0, pin_prev: '0, wkfl: '0, rdata: '0,
               sysclk: LPM_SYS_MSI, msir: LPM_MSI_8M, lost: 1'b0, wake: 1'b0,
               io_pull: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // Mode decode to power and clock controls, registered.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_clk_en <= 1'b1;
      core_clk_en <= 1'b1;
      core_power_on <= 1'b1;
      main_reg_on <= 1'b1;
      lp_reg_on <= 1'b0;
      low_leak <= 1'b0;
      pll_en <= 1'b0;
      msi_en <= 1'b1;
      hsi_en <= 1'b0;
      hse_en <= 1'b0;
      slow_osc_en <= 1'b1;
      bor_en <= 1'b1;
      cpu_fast_ok <= 1'b1;
      flash_pd <= 1'b0;
      main_sram_clk_en <= 1'b1;
      ret_sram_clk_en <= 1'b1;
      main_sram_pwr <= 1'b1;
      ret_sram_pwr <= 1'b1;
      periph_clk_en <= '1;
    end else begin
      cpu_clk_en <= !sleep_m && !stop_m && !stby_m;
      core_clk_en <= !stop_m && !stby_m;
      core_power_on <= !stby_m;
      main_reg_on <= (s_q.mode == LPM_RUN) || (s_q.mode == LPM_SLEEP) ||
                     (s_q.mode == LPM_STOP0);
      lp_reg_on <= (s_q.mode == LPM_LP_RUN) || (s_q.mode == LPM_LP_SLEEP) ||
                   (s_q.mode == LPM_STOP1) || (s_q.mode == LPM_STOP2) ||
                   ((s_q.mode == LPM_STANDBY) && s_q.ctrl[LPM_CTRL_SRAM2RET]);
      low_leak <= (s_q.mode == LPM_STOP2);
      pll_en <= !stop_m && !stby_m && (s_q.mode != LPM_LP_RUN) &&
                (s_q.mode != LPM_LP_SLEEP) && s_q.clkg[LPM_NPERIPH];
      msi_en <= !stop_m && !stby_m;
      hsi_en <= (!stop_m && !stby_m && s_q.sysclk == LPM_SYS_HSI) ||
                (stop_m && hsi_request);
      hse_en <= !stop_m && !stby_m && s_q.clkg[LPM_NPERIPH+1];
      slow_osc_en <= 1'b1;
      bor_en <= (s_q.mode != LPM_SHUTDOWN);
      cpu_fast_ok <= (s_q.mode == LPM_RUN) || (s_q.mode == LPM_SLEEP);
      flash_pd <= s_q.ctrl[LPM_CTRL_FLASHPD] || stop_m || stby_m;
      main_sram_clk_en <= !stop_m && !stby_m &&
                          !(sleep_m && s_q.clkg[LPM_NPERIPH+2]);
      ret_sram_clk_en <= !stop_m && !stby_m &&
                         !(sleep_m && s_q.clkg[LPM_NPERIPH+3]);
      main_sram_pwr <= !stby_m;
      ret_sram_pwr <= !stby_m || ((s_q.mode == LPM_STANDBY) &&
                      s_q.ctrl[LPM_CTRL_SRAM2RET]);
      periph_clk_en <= (stop_m || stby_m) ? '0 : s_q.clkg[LPM_NPERIPH-1:0];
    end
  end

  // Registered mirrors of state.
  assign rdata = s_q.rdata;
  assign sysclk_sel = s_q.sysclk;
  assign msi_range = s_q.msir;
  assign io_pull = s_q.io_pull;
  assign regs_lost = s_q.lost;
  assign wake_pulse = s_q.wake;

endmodule

// ### lpm_checker.sv
`timescale 1ns/1ps
// Watches the power-mode outputs of the controller for illegal combinations.
module lpm_checker
  import lpm_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, high.
  input wire logic hsi_request, // Fast RC request from a peripheral.
  input wire logic cpu_clk_en, // CPU clock enable.
  input wire logic core_clk_en, // Core clock enable.
  input wire logic core_power_on, // Core domain powered.
  input wire logic main_reg_on, // Main regulator on.
  input wire logic lp_reg_on, // Low-power regulator on.
  input wire logic low_leak, // Lower-leakage state.
  input wire logic pll_en, // PLL enable.
  input wire logic msi_en, // Multispeed RC enable.
  input wire logic hsi_en, // Fast RC enable.
  input wire logic hse_en, // Fast external oscillator enable.
  input wire logic [1:0] sysclk_sel, // System clock source.
  input wire logic [1:0] msi_range, // Multispeed RC range.
  input wire logic cpu_fast_ok, // CPU may exceed 2 MHz.
  input wire logic main_sram_pwr, // Main SRAM powered.
  input wire logic regs_lost, // Register loss pulse.
  input wire logic wake_pulse // Wakeup pulse.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // A stop level: core powered but its clocks halted.
  sequence s_stopped;
    core_power_on && !core_clk_en;
  endsequence
  // Power-up out of standby: the core comes back on after a standby exit.
  sequence s_core_back;
    $rose(core_power_on);
  endsequence
  // Reset must hold the device in plain run mode.
  a_reset_run_mode: assert property (disable iff (1'b0) rst |-> cpu_clk_en && main_reg_on && !lp_reg_on)
    else $error("reset does not hold run mode");
  a_lp_run_slow: assert property (cpu_clk_en && lp_reg_on |-> !cpu_fast_ok && !main_reg_on)
    else $error("low-power run with fast cpu or main regulator");
  a_stop_osc_off: assert property (!core_clk_en |-> !pll_en && !msi_en && !hse_en)
    else $error("fast oscillator running with core clocks stopped");
  a_stop_hsi_grant: assert property (s_stopped ##0 hsi_request |-> ##[0:2] hsi_en)
    else $error("fast rc request not granted in stop");
  a_leak_lp_reg: assert property (low_leak |-> lp_reg_on && !main_reg_on && !core_clk_en)
    else $error("lower-leakage state outside stop level 2");
  a_standby_all_off: assert property (!core_power_on |-> !pll_en && !msi_en && !hsi_en && !hse_en && !main_reg_on)
    else $error("clock or regulator on with core powered off");
  a_lost_sram_off: assert property (regs_lost |-> ##[0:2] !main_sram_pwr)
    else $error("main sram still powered after register loss");
  a_standby_exit_clk: assert property (s_core_back |-> ##[0:1] (msi_range == LPM_MSI_8M && sysclk_sel == LPM_SYS_MSI))
    else $error("wrong system clock after standby exit");
  a_wake_cpu_runs: assert property (wake_pulse |-> ##[0:2] cpu_clk_en)
    else $error("cpu clock not restored after wakeup");
endmodule
bind lpm_controller lpm_checker u_lpm_checker (.clock, .rst, .hsi_request, .cpu_clk_en,
  .core_clk_en, .core_power_on, .main_reg_on, .lp_reg_on, .low_leak, .pll_en, .msi_en, .hsi_en,
  .hse_en, .sysclk_sel, .msi_range, .cpu_fast_ok, .main_sram_pwr, .regs_lost, .wake_pulse);

// ### lpm_wake_model.sv
`timescale 1ns/1ps
// Wakeup sources: each requested source raises its line for one cycle after the request.
module lpm_wake_model
  import lpm_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic [LPM_NWK-1:0] fire, // One-cycle source requests.
  output logic [LPM_NPINS-1:0] wakeup_pin, // Pins, a rising edge then low again.
  output logic cpu_irq, // Interrupt or event.
  output logic rtc_event, // RTC event.
  output logic wdg_reset, // Watchdog reset.
  output logic css_fail, // Slow oscillator failure.
  output logic uart_wake, // UART receiver event.
  output logic lpuart_wake, // Low-power UART event.
  output logic i2c_addr_match, // I2C address match.
  output logic usb_wake // USB resume or attach.
);
  logic [LPM_NWK-1:0] ev_q = '0;
  // Registers the requests so that every event is a clean one-cycle pulse.
  always @(posedge clock) begin
    ev_q <= fire;
  end
  // Fans the pulses out to the individual source lines.
  assign wakeup_pin = ev_q[LPM_NPINS-1:0];
  assign rtc_event = ev_q[LPM_WK_RTC];
  assign wdg_reset = ev_q[LPM_WK_WDG];
  assign css_fail = ev_q[LPM_WK_CSS];
  assign uart_wake = ev_q[LPM_WK_UART];
  assign lpuart_wake = ev_q[LPM_WK_LPUART];
  assign i2c_addr_match = ev_q[LPM_WK_I2C];
  assign usb_wake = ev_q[LPM_WK_USB];
  assign cpu_irq = ev_q[LPM_WK_IRQ];
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  import lpm_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hsi_request = 1'b0;
  logic [LPM_NWK-1:0] fire = '0;
  logic [31:0] rdata, rnd, exp_v;
  logic [LPM_NPINS-1:0] wakeup_pin;
  logic cpu_irq, rtc_event, wdg_reset, css_fail, uart_wake, lpuart_wake, i2c_addr_match, usb_wake;
  logic cpu_clk_en, core_clk_en, core_power_on, main_reg_on, lp_reg_on, low_leak, pll_en, msi_en;
  logic hsi_en, hse_en, slow_osc_en, bor_en, cpu_fast_ok, flash_pd, main_sram_clk_en;
  logic ret_sram_clk_en, main_sram_pwr, ret_sram_pwr, regs_lost, wake_pulse, rd_d;
  logic [1:0] sysclk_sel, msi_range, io_pull;
  logic [LPM_NPERIPH-1:0] periph_clk_en;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int checked = 0;
  int lv, md;
  always #5 clock = ~clock;
  lpm_controller u_lpm_controller (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .wakeup_pin,
    .cpu_irq, .rtc_event, .wdg_reset, .css_fail, .uart_wake, .lpuart_wake, .i2c_addr_match,
    .usb_wake, .hsi_request, .cpu_clk_en, .core_clk_en, .core_power_on, .main_reg_on, .lp_reg_on,
    .low_leak, .pll_en, .msi_en, .hsi_en, .hse_en, .slow_osc_en, .bor_en, .sysclk_sel, .msi_range,
    .cpu_fast_ok, .flash_pd, .main_sram_clk_en, .ret_sram_clk_en, .main_sram_pwr, .ret_sram_pwr,
    .periph_clk_en, .io_pull, .regs_lost, .wake_pulse);
  lpm_wake_model u_lpm_wake_model (.clock, .fire, .wakeup_pin, .cpu_irq, .rtc_event, .wdg_reset,
    .css_fail, .uart_wake, .lpuart_wake, .i2c_addr_match, .usb_wake);
  // Compares one result with its expectation and counts it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read data stands in the cycle after the strobe; the oldest note is matched there.
  always @(posedge clock) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      chk(rdata, exp_v);
    end
    rd_d <= rd;
  end
  // Next value of the xorshift sequence.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask
  // Pulses one wakeup source through the source model.
  task automatic kick(input int i);
    @(posedge clock);
    fire <= {{(LPM_NWK-1){1'b0}}, 1'b1} << i;
    @(posedge clock);
    fire <= '0;
  endtask
  // Waits, bounded, for the design to report the end of a low-power mode.
  task automatic wait_wake();
    int n;
    n = 0;
    while (wake_pulse !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n < 50), 32'h1);
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Cuts a hang short at 20000 cycles, well beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    rnd = 32'h3bc5;
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    chk({cpu_clk_en, main_reg_on, bor_en, lp_reg_on}, 4'he);
    chk(periph_clk_en, 16'hffff);
    rreg(LPM_ADDR_CTRL, LPM_CTRL_RST);
    rreg(LPM_ADDR_CLKG, LPM_CLKG_RST);
    rreg(4'hf, 32'h0);
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      wreg(LPM_ADDR_CLKG, rnd);
      settle();
      chk(periph_clk_en, rnd[15:0]);
      chk({slow_osc_en, pll_en, hse_en}, {1'b1, rnd[16], rnd[17]});
    end
    wreg(LPM_ADDR_WKEN, 32'h1fff);
    wreg(LPM_ADDR_CLKG, 32'h0004ffff);
    wreg(LPM_ADDR_CTRL, 32'h80);
    settle();
    chk(flash_pd, 1'b1);
    wreg(LPM_ADDR_CTRL, 32'h11);
    settle();
    chk({cpu_clk_en, core_clk_en, main_sram_clk_en, ret_sram_clk_en}, 4'h5);
    kick(LPM_WK_IRQ);
    wait_wake();
    wreg(LPM_ADDR_CTRL, 32'h13);
    settle();
    rreg(LPM_ADDR_STAT, 32'h0);
    wreg(LPM_ADDR_CTRL, 32'h12);
    settle();
    rreg(LPM_ADDR_STAT, 32'h2);
    chk({lp_reg_on, main_reg_on, cpu_fast_ok}, 3'h4);
    wreg(LPM_ADDR_CTRL, 32'h11);
    settle();
    rreg(LPM_ADDR_STAT, 32'h3);
    kick(LPM_WK_IRQ);
    wait_wake();
    settle();
    rreg(LPM_ADDR_STAT, 32'h2);
    do_reset();
    rreg(LPM_ADDR_STAT, 32'h0);
    // Each stop level, woken by the UART, low-power UART, I2C and USB sources in turn.
    for (int k = 0; k < 4; k++) begin
      lv = k % 3;
      wreg(LPM_ADDR_WKEN, 32'h1fff);
      wreg(LPM_ADDR_CTRL, 32'(32'h14 + lv + 32 * (lv % 2)));
      settle();
      chk({core_clk_en, main_reg_on, low_leak, msi_en}, {1'b0, lv == 0, lv == 2, 1'b0});
      hsi_request <= 1'b1;
      settle();
      chk(hsi_en, 1'b1);
      hsi_request <= 1'b0;
      kick(LPM_WK_UART + k);
      wait_wake();
      settle();
      rreg(LPM_ADDR_STAT, (lv % 2 == 1) ? 32'h10 : 32'h0);
    end
    wreg(LPM_ADDR_WKEN, 32'h1eff);
    wreg(LPM_ADDR_CTRL, 32'h15);
    kick(LPM_WK_UART);
    repeat (5) @(posedge clock);
    rreg(LPM_ADDR_STAT, 32'h5);
    kick(LPM_WK_RTC);
    wait_wake();
    // Standby woken by every pin, RTC, watchdog and clock monitor, then shutdown by a pin.
    for (int i = 0; i < 9; i++) begin
      md = (i == 8) ? 8 : 7;
      wreg(LPM_ADDR_WKEN, 32'h1fff);
      wreg(LPM_ADDR_PULL, (md == 7) ? 32'h1 : 32'h2);
      wreg(LPM_ADDR_CTRL, 32'(32'h50 + md));
      @(posedge clock);
      chk(regs_lost, 1'b1);
      settle();
      chk({core_power_on, io_pull, bor_en, ret_sram_pwr, main_sram_pwr},
          (md == 7) ? 6'h0e : 6'h10);
      kick((i == 8) ? 0 : i);
      wait_wake();
      settle();
      chk({core_power_on, msi_range, sysclk_sel, io_pull}, {1'b1, LPM_MSI_8M, LPM_SYS_MSI, 2'h0});
      rreg(LPM_ADDR_CLKG, LPM_CLKG_RST);
    end
    rreg(LPM_ADDR_PULL, 32'h2);
    settle();
    tally_and_finish();
  end
endmodule
